// ===== hw/ppc_pkg.sv
package ppc_pkg;

  // Port geometry.
  localparam int unsigned PORT_W    = 8;
  localparam int unsigned NUM_PORTS = 3;
  localparam int unsigned NUM_PINS  = PORT_W * NUM_PORTS;
  localparam int unsigned NUM_FN    = 6;
  localparam int unsigned STEER_W   = 8;
  localparam int unsigned BUS_W     = 32;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned BE_W      = 4;

  // Request that a peripheral places on the pin it is steered to.
  typedef struct packed {
    logic own;
    logic oe;
    logic out;
  } ppc_fn_t;

  // Register byte addresses; port p adds p times the stride.
  localparam logic [ADDR_W-1:0] OFS_PORT_STRIDE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LEVEL       = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_LATCH       = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DIR         = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ANSEL       = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STEER       = 8'h30;

  // Reset values.
  localparam logic [PORT_W-1:0]  RST_DIR   = 8'hFF;
  localparam logic [PORT_W-1:0]  RST_ANSEL = 8'hFF;
  localparam logic [PORT_W-1:0]  RST_LATCH = 8'h00;
  localparam logic [STEER_W-1:0] RST_STEER = 8'h00;

  // Select bit positions in alternate_pin_select.
  localparam int unsigned SEL_CAPCMP2  = 0;
  localparam int unsigned SEL_RECEIVE  = 1;
  localparam int unsigned SEL_SER_IN   = 3;
  localparam int unsigned SEL_SER_CLK  = 4;
  localparam int unsigned SEL_SER_OUT  = 5;
  localparam int unsigned SEL_CAPCMP1  = 6;

  // Function slots; a lower slot wins a pin that two functions claim.
  localparam int unsigned FN_CAPCMP1 = 0;
  localparam int unsigned FN_SER_OUT = 1;
  localparam int unsigned FN_SER_CLK = 2;
  localparam int unsigned FN_SER_IN  = 3;
  localparam int unsigned FN_RECEIVE = 4;
  localparam int unsigned FN_CAPCMP2 = 5;

  // Flat pin indices: port A 0..7, port B 8..15, port C 16..23.
  localparam int unsigned PIN_PORTB_PIN0 = 8;
  localparam int unsigned PIN_PORTB_PIN3 = 11;
  localparam int unsigned PIN_PORTB_PIN5 = 13;
  localparam int unsigned PIN_PORTB_PIN6 = 14;
  localparam int unsigned PIN_PORTB_PIN7 = 15;
  localparam int unsigned PIN_PORTC_PIN1 = 17;
  localparam int unsigned PIN_PORTC_PIN2 = 18;
  localparam int unsigned PIN_PORTC_PIN3 = 19;
  localparam int unsigned PIN_PORTC_PIN4 = 20;
  localparam int unsigned PIN_PORTC_PIN5 = 21;
  localparam int unsigned PIN_PORTC_PIN7 = 23;

endpackage

// ===== hw/ppc_pin_cell.sv
`timescale 1ns/1ps
module ppc_pin_cell (
  // Clock and reset.
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  // Port registers.
  input  wire logic i_latch,
  input  wire logic i_dir,
  input  wire logic i_ansel,
  // Peripheral override.
  input  wire logic i_own,
  input  wire logic i_fn_out,
  input  wire logic i_fn_oe,
  // Pin.
  input  wire logic i_pin_in,
  output logic      o_pin_out,
  output logic      o_pin_oe,
  output logic      o_din
);

  logic out_next;
  logic oe_next;
  logic din_next;

  assign out_next = i_own ? i_fn_out : i_latch;
  assign oe_next  = i_own ? i_fn_oe : ~i_dir;
  assign din_next = i_pin_in & ~i_ansel;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_pin_out <= 1'b0;
      o_pin_oe  <= 1'b0;
      o_din     <= 1'b0;
    end else begin
      o_pin_out <= out_next;
      o_pin_oe  <= oe_next;
      o_din     <= din_next;
    end
  end

  owned_pin_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_own |=> (o_pin_out == $past(i_fn_out)) && (o_pin_oe == $past(i_fn_oe)))
    else $error("Owned pin does not follow its peripheral.");

  plain_pin_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_own |=> (o_pin_oe == !$past(i_dir)) && (o_pin_out == $past(i_latch)))
    else $error("Unowned pin does not follow direction and latch.");

  analog_zero_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ansel |=> !o_din)
    else $error("Analog pin reads as one.");

endmodule

// ===== hw/ppc_steer.sv
`timescale 1ns/1ps
module ppc_steer #(
  parameter int unsigned NUM_PINS = 24,
  parameter int unsigned NUM_FN   = 6,
  parameter int unsigned STEER_W  = 8,
  parameter int unsigned SEL_BIT [NUM_FN] = '{default: 0},
  parameter int unsigned SET_PIN [NUM_FN] = '{default: 0},
  parameter int unsigned CLR_PIN [NUM_FN] = '{default: 0}
) (
  // Select register and peripherals.
  input  wire logic [STEER_W-1:0]             i_sel,
  input  wire ppc_pkg::ppc_fn_t [NUM_FN-1:0]  i_fn_req,
  output logic [NUM_FN-1:0]                   o_fn_in,
  // Per-pin view.
  input  wire logic [NUM_PINS-1:0]            i_din,
  output logic [NUM_PINS-1:0]                 o_own,
  output logic [NUM_PINS-1:0]                 o_out,
  output logic [NUM_PINS-1:0]                 o_oe
);

  // Pin currently chosen for each function.
  int unsigned fn_pin [NUM_FN];

  always_comb begin
    for (int f = 0; f < NUM_FN; f++) begin
      fn_pin[f]  = i_sel[SEL_BIT[f]] ? SET_PIN[f] : CLR_PIN[f];
      o_fn_in[f] = i_din[fn_pin[f]];
    end
  end

  // Only the chosen pin sees a function; the other keeps plain behaviour.
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    always_comb begin
      o_own[p] = 1'b0;
      o_out[p] = 1'b0;
      o_oe[p]  = 1'b0;
      for (int f = NUM_FN - 1; f >= 0; f--) begin
        if (fn_pin[f] == p && i_fn_req[f].own) begin
          o_own[p] = 1'b1;
          o_out[p] = i_fn_req[f].out;
          o_oe[p]  = i_fn_req[f].oe;
        end
      end
    end
  end

endmodule

// ===== hw/ppc_port_ctrl.sv
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - A peripheral owning a pin blocks the output latch; pin reads still work.
// - Writing the pin level register updates the output latch bits.
// - Reading the output latch register returns the stored latch bits.
// - Reading the pin level register returns sampled pin levels.
// - Analog-select bit set disables that pin's digital input.
// - An eight-bit select register steers peripheral signals between pins.
// - Changing select bits never alters any direction register.
// - Peripheral level and direction overrides follow the function's new pin.
// - The unselected pin keeps its ordinary behaviour.
// - Select bit 6 set puts capture/compare channel 1 on port B pin 0.
// - Select bit 3 puts serial data on port B pin 6, else C4.
// - Select bit 1 puts serial receive on port B pin 7, else C7; serial clock (bit 4) wins B7 if both claim it.
// - Direction 1 makes the pin input; 0 drives the latch out.
// - An analog-selected pin reads 0 on digital reads.
module ppc_port_ctrl #(
  // Arbitrary defaults for the pins that are not known.
  parameter int unsigned CAPCMP1_CLR_PIN = ppc_pkg::PIN_PORTC_PIN2,
  parameter int unsigned CAPCMP2_SET_PIN = ppc_pkg::PIN_PORTB_PIN3
) (
  // Clock and reset.
  input  wire logic                                   i_core_clk,
  input  wire logic                                   i_rst,
  // Avalon-MM slave.
  input  wire logic [ppc_pkg::ADDR_W-1:0]             i_avs_address,
  input  wire logic                                   i_avs_read,
  input  wire logic                                   i_avs_write,
  input  wire logic [ppc_pkg::BUS_W-1:0]              i_avs_writedata,
  input  wire logic [ppc_pkg::BE_W-1:0]               i_avs_byteenable,
  output logic [ppc_pkg::BUS_W-1:0]                   o_avs_readdata,
  output logic                                        o_avs_waitrequest,
  // Pins.
  input  wire logic [ppc_pkg::NUM_PINS-1:0]           i_pin_in,
  output logic [ppc_pkg::NUM_PINS-1:0]                o_pin_out,
  output logic [ppc_pkg::NUM_PINS-1:0]                o_pin_oe,
  // Steerable peripheral functions.
  input  wire ppc_pkg::ppc_fn_t [ppc_pkg::NUM_FN-1:0] i_fn_req,
  output logic [ppc_pkg::NUM_FN-1:0]                  o_fn_in
);

  localparam int unsigned PW  = ppc_pkg::PORT_W;
  localparam int unsigned NP  = ppc_pkg::NUM_PORTS;
  localparam int unsigned NPN = ppc_pkg::NUM_PINS;
  localparam int unsigned NF  = ppc_pkg::NUM_FN;
  localparam int unsigned SW  = ppc_pkg::STEER_W;

  localparam int unsigned FN_SEL [NF] = '{
    ppc_pkg::SEL_CAPCMP1, ppc_pkg::SEL_SER_OUT, ppc_pkg::SEL_SER_CLK,
    ppc_pkg::SEL_SER_IN,  ppc_pkg::SEL_RECEIVE, ppc_pkg::SEL_CAPCMP2};
  localparam int unsigned FN_SET [NF] = '{
    ppc_pkg::PIN_PORTB_PIN0,
    ppc_pkg::PIN_PORTB_PIN5,
    ppc_pkg::PIN_PORTB_PIN7,
    ppc_pkg::PIN_PORTB_PIN6,
    ppc_pkg::PIN_PORTB_PIN7,
    CAPCMP2_SET_PIN};
  localparam int unsigned FN_CLR [NF] = '{
    CAPCMP1_CLR_PIN,
    ppc_pkg::PIN_PORTC_PIN5,
    ppc_pkg::PIN_PORTC_PIN3,
    ppc_pkg::PIN_PORTC_PIN4,
    ppc_pkg::PIN_PORTC_PIN7,
    ppc_pkg::PIN_PORTC_PIN1};

  // Port registers, flat across ports.
  logic [NPN-1:0] dir_reg;
  logic [NPN-1:0] latch_reg;
  logic [NPN-1:0] ansel_reg;
  logic [SW-1:0]  steer_reg;
  logic [NPN-1:0] din;

  // Bus handshake state.
  logic                      ack_reg;
  logic [ppc_pkg::BUS_W-1:0] rdata_reg;
  logic [ppc_pkg::BUS_W-1:0] rdata_next;

  wire req    = i_avs_read | i_avs_write;
  wire wr_go  = i_avs_write & ack_reg & i_avs_byteenable[0];
  wire rd_cap = i_avs_read & ~ack_reg;

  assign o_avs_waitrequest = req & ~ack_reg;
  assign o_avs_readdata    = rdata_reg;

  wire hit_steer = (i_avs_address == ppc_pkg::OFS_STEER);

  logic [NP-1:0] hit_level;
  logic [NP-1:0] hit_latch;
  logic [NP-1:0] hit_dir;
  logic [NP-1:0] hit_ansel;
  logic [PW-1:0] rd_part [NP];

  for (genvar p = 0; p < NP; p++) begin : g_port
    localparam logic [ppc_pkg::ADDR_W-1:0] BASE =
      ppc_pkg::ADDR_W'(p * ppc_pkg::OFS_PORT_STRIDE);

    assign hit_level[p] = i_avs_address == (BASE | ppc_pkg::OFS_LEVEL);
    assign hit_latch[p] = i_avs_address == (BASE | ppc_pkg::OFS_LATCH);
    assign hit_dir[p]   = i_avs_address == (BASE | ppc_pkg::OFS_DIR);
    assign hit_ansel[p] = i_avs_address == (BASE | ppc_pkg::OFS_ANSEL);

    wire wr_latch = wr_go & (hit_level[p] | hit_latch[p]);
    wire wr_dir   = wr_go & hit_dir[p];
    wire wr_ansel = wr_go & hit_ansel[p];

    // Level reads see the sampled pins, latch reads see the latch.
    assign rd_part[p] =
      ({PW{hit_level[p]}} & din[p*PW +: PW])       |
      ({PW{hit_latch[p]}} & latch_reg[p*PW +: PW]) |
      ({PW{hit_dir[p]}}   & dir_reg[p*PW +: PW])   |
      ({PW{hit_ansel[p]}} & ansel_reg[p*PW +: PW]);

    always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
        latch_reg[p*PW +: PW] <= ppc_pkg::RST_LATCH;
        dir_reg[p*PW +: PW]   <= ppc_pkg::RST_DIR;
        ansel_reg[p*PW +: PW] <= ppc_pkg::RST_ANSEL;
      end else begin
        if (wr_latch) begin
          latch_reg[p*PW +: PW] <= i_avs_writedata[PW-1:0];
        end
        if (wr_dir) begin
          dir_reg[p*PW +: PW] <= i_avs_writedata[PW-1:0];
        end
        if (wr_ansel) begin
          ansel_reg[p*PW +: PW] <= i_avs_writedata[PW-1:0];
        end
      end
    end
  end

  always_comb begin
    rdata_next = '0;
    for (int p = 0; p < NP; p++) begin
      rdata_next[PW-1:0] = rdata_next[PW-1:0] | rd_part[p];
    end
    if (hit_steer) begin
      rdata_next[SW-1:0] = steer_reg;
    end
  end

  // One wait cycle per access; unmapped reads return zero.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (rd_cap) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // Select register touches nothing but itself.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      steer_reg <= ppc_pkg::RST_STEER;
    end else if (wr_go & hit_steer) begin
      steer_reg <= i_avs_writedata[SW-1:0];
    end
  end

  logic [NPN-1:0] own;
  logic [NPN-1:0] fn_out;
  logic [NPN-1:0] fn_oe;

  ppc_steer #(
    .NUM_PINS (NPN),
    .NUM_FN   (NF),
    .STEER_W  (SW),
    .SEL_BIT  (FN_SEL),
    .SET_PIN  (FN_SET),
    .CLR_PIN  (FN_CLR)
  ) u_steer (
    .i_sel    (steer_reg),
    .i_fn_req (i_fn_req),
    .o_fn_in  (o_fn_in),
    .i_din    (din),
    .o_own    (own),
    .o_out    (fn_out),
    .o_oe     (fn_oe)
  );

  for (genvar i = 0; i < NPN; i++) begin : g_cell
    ppc_pin_cell u_cell (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_latch    (latch_reg[i]),
      .i_dir      (dir_reg[i]),
      .i_ansel    (ansel_reg[i]),
      .i_own      (own[i]),
      .i_fn_out   (fn_out[i]),
      .i_fn_oe    (fn_oe[i]),
      .i_pin_in   (i_pin_in[i]),
      .o_pin_out  (o_pin_out[i]),
      .o_pin_oe   (o_pin_oe[i]),
      .o_din      (din[i])
    );
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  localparam int unsigned P_B0 = ppc_pkg::PIN_PORTB_PIN0;
  localparam int unsigned P_B5 = ppc_pkg::PIN_PORTB_PIN5;
  localparam int unsigned P_B6 = ppc_pkg::PIN_PORTB_PIN6;
  localparam int unsigned P_B7 = ppc_pkg::PIN_PORTB_PIN7;
  localparam int unsigned P_C1 = ppc_pkg::PIN_PORTC_PIN1;
  localparam int unsigned P_C4 = ppc_pkg::PIN_PORTC_PIN4;
  localparam int unsigned P_C5 = ppc_pkg::PIN_PORTC_PIN5;
  localparam int unsigned P_C7 = ppc_pkg::PIN_PORTC_PIN7;

  sequence s_sdi_high;
    steer_reg[ppc_pkg::SEL_SER_IN] && i_fn_req[ppc_pkg::FN_SER_IN].own;
  endsequence

  sequence s_rx_high;
    steer_reg[ppc_pkg::SEL_RECEIVE] && !steer_reg[ppc_pkg::SEL_SER_CLK]
      && i_fn_req[ppc_pkg::FN_RECEIVE].own;
  endsequence

  bus_answer_a: assert property (
    (req && o_avs_waitrequest) |=> !o_avs_waitrequest ##1 !ack_reg)
    else $error("Bus access not answered after one wait cycle.");

  level_to_latch_a: assert property (
    (wr_go && hit_level[1]) |=> latch_reg[2*PW-1:PW] ==
      $past(i_avs_writedata[PW-1:0]))
    else $error("Level register write missed the latch.");

  latch_read_a: assert property (
    (rd_cap && hit_latch[1]) |=> o_avs_readdata[PW-1:0] ==
      $past(latch_reg[2*PW-1:PW]))
    else $error("Latch read returned wrong data.");

  level_read_a: assert property (
    (rd_cap && hit_level[1]) |=> o_avs_readdata[PW-1:0] ==
      $past(din[2*PW-1:PW]))
    else $error("Level read did not return sampled pins.");

  steer_keeps_dir_a: assert property (
    (wr_go && hit_steer) |=> $stable(dir_reg))
    else $error("Select write changed a direction bit.");

  steer_reset_a: assert property (disable iff (1'b0)
    i_rst |=> steer_reg == ppc_pkg::RST_STEER)
    else $error("Select register not cleared by reset.");

  sdi_moves_a: assert property (
    s_sdi_high |=> o_pin_oe[P_B6] ==
      $past(i_fn_req[ppc_pkg::FN_SER_IN].oe) &&
      o_pin_oe[P_C4] == !$past(dir_reg[P_C4]))
    else $error("Serial data not steered to port B pin 6.");

  rx_moves_a: assert property (
    s_rx_high |=> o_pin_out[P_B7] ==
      $past(i_fn_req[ppc_pkg::FN_RECEIVE].out))
    else $error("Receive not steered to port B pin 7.");

  fn_in_a: assert property (
    steer_reg[ppc_pkg::SEL_SER_IN] |->
      o_fn_in[ppc_pkg::FN_SER_IN] == din[P_B6])
    else $error("Serial data input taken from wrong pin.");

  rx_idle_pin_a: assert property (
    s_rx_high |=> o_pin_oe[P_C7] == !$past(dir_reg[P_C7]) &&
      o_pin_out[P_C7] == $past(latch_reg[P_C7]))
    else $error("Receive clear pin lost its plain behaviour.");

  sequence s_sdo_high;
    steer_reg[ppc_pkg::SEL_SER_OUT] && i_fn_req[ppc_pkg::FN_SER_OUT].own;
  endsequence

  sdo_moves_a: assert property (
    s_sdo_high |=> o_pin_out[P_B5] ==
      $past(i_fn_req[ppc_pkg::FN_SER_OUT].out) &&
      o_pin_oe[P_C5] == !$past(dir_reg[P_C5]))
    else $error("Serial out not steered to port B pin 5.");

  capcmp1_set_a: assert property (
    steer_reg[ppc_pkg::SEL_CAPCMP1] && i_fn_req[ppc_pkg::FN_CAPCMP1].own
      |=> o_pin_oe[P_B0] == $past(i_fn_req[ppc_pkg::FN_CAPCMP1].oe))
    else $error("First capture channel not on port B pin 0.");

  capcmp2_clear_a: assert property (
    !steer_reg[ppc_pkg::SEL_CAPCMP2] && i_fn_req[ppc_pkg::FN_CAPCMP2].own
      |=> o_pin_out[P_C1] == $past(i_fn_req[ppc_pkg::FN_CAPCMP2].out))
    else $error("Second capture channel not on port C pin 1.");

  latch_write_a: assert property (
    (wr_go && hit_latch[1]) |=> latch_reg[2*PW-1:PW] ==
      $past(i_avs_writedata[PW-1:0]))
    else $error("Latch register write missed the latch.");

  steer_write_a: assert property (
    (wr_go && hit_steer) |=> steer_reg == $past(i_avs_writedata[SW-1:0]))
    else $error("Select register write did not land.");

  analog_read_a: assert property (
    (rd_cap && hit_level[0] && $stable(ansel_reg[PW-1:0])) |=>
      (o_avs_readdata[PW-1:0] & $past(ansel_reg[PW-1:0])) == '0)
    else $error("Analog pin read back as one.");

  rdata_upper_a: assert property (
    o_avs_readdata[ppc_pkg::BUS_W-1:PW] == '0)
    else $error("Read data upper bits not zero.");

endmodule

// ===== testbench/ppc_pin_model.sv
`timescale 1ns/1ps
// Stands for the board and the on-chip peripherals on the far side.
module ppc_pin_model (
  // Pin drive from the port.
  input  wire logic [ppc_pkg::NUM_PINS-1:0]           i_pin_out,
  input  wire logic [ppc_pkg::NUM_PINS-1:0]           i_pin_oe,
  // Level the board puts on pins that the port leaves undriven.
  input  wire logic [ppc_pkg::NUM_PINS-1:0]           i_ext,
  // Peripheral requests, one bit per function slot.
  input  wire logic [ppc_pkg::NUM_FN-1:0]             i_fn_own,
  input  wire logic [ppc_pkg::NUM_FN-1:0]             i_fn_oe,
  input  wire logic [ppc_pkg::NUM_FN-1:0]             i_fn_out,
  // Resulting pin levels and packed requests.
  output logic [ppc_pkg::NUM_PINS-1:0]                o_pin_in,
  output ppc_pkg::ppc_fn_t [ppc_pkg::NUM_FN-1:0]      o_fn_req
);
  // A driven pin shows the port's value, otherwise the board's level.
  assign o_pin_in = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext);

  for (genvar f = 0; f < ppc_pkg::NUM_FN; f++) begin : g_fn
    assign o_fn_req[f] = {i_fn_own[f], i_fn_oe[f], i_fn_out[f]};
  end
endmodule

// ===== testbench/tb_port_pin_control_with_steering.sv
`timescale 1ns/1ps
module tb_port_pin_control_with_steering;
  typedef struct packed {
    logic       w;
    logic [3:0] be;
    logic [7:0] a;
    logic [7:0] d;
  } ppc_row_t;

  localparam int unsigned C1CLR = ppc_pkg::PIN_PORTC_PIN2;
  localparam int unsigned C2SET = ppc_pkg::PIN_PORTB_PIN3;
  localparam int unsigned SB [6] = '{6, 5, 4, 3, 1, 0};
  localparam int unsigned SP [6] = '{8, 13, 15, 14, 15, C2SET};
  localparam int unsigned CP [6] = '{C1CLR, 21, 19, 20, 23, 17};
  localparam ppc_row_t ROWS [17] = '{
    '{1'b0, 4'hF, 8'h08, 8'hFF}, '{1'b0, 4'hF, 8'h1C, 8'hFF},
    '{1'b0, 4'hF, 8'h24, 8'h00}, '{1'b0, 4'hF, 8'h30, 8'h00},
    '{1'b1, 4'hF, 8'h1C, 8'h00}, '{1'b1, 4'hF, 8'h2C, 8'h00},
    '{1'b1, 4'hF, 8'h18, 8'h0F}, '{1'b1, 4'hF, 8'h10, 8'hA5},
    '{1'b0, 4'hF, 8'h14, 8'hA5}, '{1'b1, 4'h0, 8'h14, 8'hFF},
    '{1'b0, 4'hF, 8'h14, 8'hA5}, '{1'b1, 4'hF, 8'h14, 8'h3C},
    '{1'b1, 4'hF, 8'h30, 8'hFF}, '{1'b0, 4'hF, 8'h30, 8'hFF},
    '{1'b0, 4'hF, 8'h18, 8'h0F}, '{1'b1, 4'hF, 8'h3C, 8'h77},
    '{1'b0, 4'hF, 8'h3C, 8'h00}};

  logic                        clk;
  logic                        rst;
  logic                        rd;
  logic                        wr;
  logic [7:0]                  addr;
  logic [31:0]                 wdata;
  logic [31:0]                 rdata;
  logic [31:0]                 got;
  logic [3:0]                  be;
  logic                        wait_rq;
  logic [23:0]                 pin_in;
  logic [23:0]                 pin_out;
  logic [23:0]                 pin_oe;
  logic [23:0]                 ext;
  logic [5:0]                  fn_in;
  logic [5:0]                  f_own;
  logic [5:0]                  f_out;
  ppc_pkg::ppc_fn_t [5:0]      fn_req;
  int                          failures;
  int                          num_checks;

  ppc_port_ctrl #(.CAPCMP1_CLR_PIN(C1CLR), .CAPCMP2_SET_PIN(C2SET)) uut (
    .i_core_clk(clk), .i_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_rq), .i_pin_in(pin_in),
    .o_pin_out(pin_out), .o_pin_oe(pin_oe), .i_fn_req(fn_req),
    .o_fn_in(fn_in));

  ppc_pin_model pm (
    .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_ext(ext), .i_fn_own(f_own),
    .i_fn_oe(f_own), .i_fn_out(f_out), .o_pin_in(pin_in),
    .o_fn_req(fn_req));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Holds the request until waitrequest is low at a rising edge.
  task automatic bus_op(input logic w, input logic [3:0] b,
                        input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    addr <= a;
    wdata <= {24'h0, d};
    be <= b;
    wr <= w;
    rd <= !w;
    forever begin
      @(posedge clk);
      if (wait_rq === 1'b0) break;
      n++;
    end
    chk("wait_cycles", 32'h1, n);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    bus_op(1'b0, 4'hF, a, 8'h00);
    chk("readdata", {24'h0, e}, got);
  endtask

  initial begin
    #400000;
    failures++;
    close_out();
  end

  initial begin
    int unsigned on;
    int unsigned off;
    failures = 0;
    num_checks = 0;
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    be = 4'h0;
    f_own = 6'h00;
    f_out = 6'h00;
    ext = 24'h005AFF;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 17; i++) begin
      if (ROWS[i].w)
        bus_op(1'b1, ROWS[i].be, ROWS[i].a, ROWS[i].d);
      else
        rdchk(ROWS[i].a, ROWS[i].d);
    end
    bus_op(1'b1, 4'hF, 8'h30, 8'h00);
    chk("oe_b", 32'hF0, {24'h0, pin_oe[15:8]});
    chk("out_b", 32'h3C, {24'h0, pin_out[15:8]});
    rdchk(8'h10, 8'h3A);
    rdchk(8'h00, 8'h00);
    bus_op(1'b1, 4'hF, 8'h14, 8'hFF);
    bus_op(1'b1, 4'hF, 8'h24, 8'hFF);
    bus_op(1'b1, 4'hF, 8'h18, 8'hFF);
    ext <= 24'hFFFFFF;
    for (int f = 0; f < 6; f++) begin
      for (int s = 0; s < 2; s++) begin
        f_own <= 6'h01 << f;
        f_out <= ~(6'h01 << f);
        bus_op(1'b1, 4'hF, 8'h30, s ? (8'h01 << SB[f]) : 8'h00);
        repeat (4) @(posedge clk);
        on = s ? SP[f] : CP[f];
        off = s ? CP[f] : SP[f];
        chk("oe_on", 32'h1, {31'h0, pin_oe[on]});
        chk("out_on", 32'h0, {31'h0, pin_out[on]});
        chk("oe_off", 32'h0, {31'h0, pin_oe[off]});
        chk("out_off", 32'h1, {31'h0, pin_out[off]});
        chk("fn_in", 32'h0, {31'h0, fn_in[f]});
      end
    end
    f_own <= 6'h00;
    rdchk(8'h28, 8'hFF);
    bus_op(1'b1, 4'hF, 8'h30, 8'hFF);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk(8'h30, 8'h00);
    rdchk(8'h14, 8'h00);
    close_out();
  end
endmodule
